/* inc/ccg_params.svh */
// Register offsets, field positions, reset values and counts of the clock generator
`ifndef CCG_PARAMS_SVH
`define CCG_PARAMS_SVH

`define CCG_ADDR_PROC_CLK   16'hFFFB
`define CCG_ADDR_SUB_OSC    16'hFFF0
`define CCG_ADDR_SUBCLK     16'hFFF2

`define CCG_PROC_CLK_RESET  8'h02
`define CCG_SUB_OSC_RESET   8'h00
`define CCG_SUBCLK_RESET    8'h00

`define CCG_BIT_MAIN_STOP   7
`define CCG_BIT_DIV_SEL     1
`define CCG_BIT_FB_RES      1
`define CCG_BIT_SUB_STOP    0
`define CCG_BIT_SUB_SEL     4
`define CCG_BIT_SRC_STAT    5

`define CCG_SW_FAST_SLOW    9'h004
`define CCG_SW_FAST_SUB     9'h132
`define CCG_SW_OTHER        9'h002

`define CCG_MAIN_DIV_LAST   2'h3
`define CCG_STAB_TICKS      32768

`endif

/* inc/ccg_pkg.sv */
// Types shared by the clock generator modules
package ccg_pkg;

   typedef struct packed {
      logic sub_clock_sel;
      logic cpu_div_sel;
   } ccg_sel_s;

   typedef enum logic [1:0] {
      ST_OFF  = 2'h0,
      ST_STAB = 2'h1,
      ST_RUN  = 2'h3,
      ST_STOP = 2'h2
   } ccg_state_e;

endpackage

/* logic/ccg_sync_edge.sv */
// Two-stage synchroniser with rising-edge pulse for an oscillator pin
`timescale 1ns/1ps
module ccg_sync_edge (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic pin,
   output logic      rise
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   assign rise = s2 & ~s3;
endmodule

/* logic/ccg_top.sv */
// CPU and peripheral clock generator with source switch, standby gating and start-up wait
// What this block does
// - Reset selects main clock divided by four; divide select bit resets to one.
// - Main oscillator stays stopped while reset is held low.
// - Three CPU clocks: main, main divided by four, subsystem divided by two.
// - With main clock selected, both stop and halt standby are allowed.
// - Feedback resistor bit in sub oscillator mode register disconnects the resistor.
// - Sub oscillator stop bit set stops subsystem oscillator; clear keeps it running.
// - Subsystem select bit switches the CPU clock to the subsystem oscillator.
// - Main stop bit stops main oscillator while subsystem clock drives the CPU.
// - With subsystem clock selected, halt is allowed but stop is refused.
// - Peripheral clocks divide the main clock; subsystem clock feeds only the watch timer.
// - Peripherals except watch timer halt when the main clock is stopped.
// - After a selection write, the old CPU clock runs on for a bounded delay.
// - Delays: fast to slow main 4, fast main to sub 306, otherwise 2.
// - Delays count CPU clocks of the selection in force before switching.
// - Reset release starts main oscillator and waits 2^15 main periods.
// - After the start-up wait the CPU runs on the divided main clock.
// - Clearing main stop bit restarts main oscillator; software then reselects high speed.
// - A divider on the main oscillator makes the derived clocks.
// - Sub select 0 and divide 0 main, 0 and 1 main/4, sub select 1 sub/2.
// - Read-only status bit shows whether the CPU runs on main or subsystem clock.
// - Reset clears subclock control and sub oscillator mode registers.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "ccg_params.svh"
module ccg_top #(
   parameter int STAB_MAIN_TICKS = `CCG_STAB_TICKS
) (
   input  wire logic        CLK_SYS,
   input  wire logic        RESETN,
   input  wire logic [15:0] REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [7:0]  REG_RDATA,
   input  wire logic        MAIN_OSC_IN,
   input  wire logic        SUB_OSC_IN,
   output logic             MAIN_OSC_EN,
   output logic             SUB_OSC_EN,
   output logic             FEEDBACK_RES_EN,
   input  wire logic        STOP_REQ,
   input  wire logic        HALT_REQ,
   input  wire logic        WAKE_REQ,
   output logic             STOP_MODE,
   output logic             HALT_MODE,
   output logic             CPU_RUN,
   output logic             CPU_CLK_EN,
   output logic      [7:0]  PERIPH_CLK_EN,
   output logic             PERIPH_RUN,
   output logic             WATCH_CLK_EN
);
   ccg_pkg::ccg_state_e state;
   ccg_pkg::ccg_state_e next_state;
   ccg_pkg::ccg_sel_s   sel_sw;
   ccg_pkg::ccg_sel_s   cur_sel;
   logic                main_osc_stop;
   logic                feedback_res_off;
   logic                sub_osc_stop;
   logic [15:0]         stab_cnt;
   logic [8:0]          sw_cnt;
   logic [1:0]          main_div;
   logic                sub_half;
   logic [7:0]          pdiv;
   logic                main_rise;
   logic                sub_rise;

   // Switch delay in CPU clocks of the selection in force
   function automatic logic [8:0] sw_limit(input ccg_pkg::ccg_sel_s from_sel,
                                           input ccg_pkg::ccg_sel_s to_sel);
      logic fast;
      fast = !from_sel.sub_clock_sel && !from_sel.cpu_div_sel;
      if (fast && to_sel.sub_clock_sel)
         return `CCG_SW_FAST_SUB;
      else if (fast && to_sel.cpu_div_sel)
         return `CCG_SW_FAST_SLOW;
      else
         return `CCG_SW_OTHER;
   endfunction

   ccg_sync_edge u_main_edge (
      .clk    (CLK_SYS),
      .resetn (RESETN),
      .pin    (MAIN_OSC_IN),
      .rise   (main_rise)
   );

   ccg_sync_edge u_sub_edge (
      .clk    (CLK_SYS),
      .resetn (RESETN),
      .pin    (SUB_OSC_IN),
      .rise   (sub_rise)
   );

   // Register decode
   wire wr_proc = REG_WR && (REG_ADDR == `CCG_ADDR_PROC_CLK);
   wire wr_sosc = REG_WR && (REG_ADDR == `CCG_ADDR_SUB_OSC);
   wire wr_sclk = REG_WR && (REG_ADDR == `CCG_ADDR_SUBCLK);

   // Main stop only bites while the CPU really runs on the subsystem clock,
   // so a misplaced write can never freeze the CPU clock itself
   wire main_stop_eff = main_osc_stop && cur_sel.sub_clock_sel;
   wire main_on = (state == ccg_pkg::ST_STAB) ||
                  ((state == ccg_pkg::ST_RUN) && !main_stop_eff);
   wire main_tick = main_rise && MAIN_OSC_EN;
   wire sub_tick  = sub_rise && SUB_OSC_EN;
   wire main_q    = main_tick && (main_div == `CCG_MAIN_DIV_LAST);
   wire sub_h     = sub_tick && sub_half;

   // CPU source tick, selected by the selection in force
   wire cpu_src_tick = cur_sel.sub_clock_sel ? sub_h :
                       (cur_sel.cpu_div_sel ? main_q : main_tick);
   wire sw_pend = (sel_sw != cur_sel);
   wire [8:0] sw_max = sw_limit(cur_sel, sel_sw);
   wire sw_done = sw_pend && cpu_src_tick &&
                  (sw_cnt == 9'(sw_max - 9'h001));
   wire stab_done = main_tick &&
                    (stab_cnt == 16'(STAB_MAIN_TICKS - 1));
   wire stop_ok = STOP_REQ && !cur_sel.sub_clock_sel &&
                  (state == ccg_pkg::ST_RUN);
   wire halt_ok = HALT_REQ && (state == ccg_pkg::ST_RUN);

   wire [7:0] rd_proc = {main_osc_stop, 5'h00, sel_sw.cpu_div_sel, 1'b0};
   wire [7:0] rd_sosc = {6'h00, feedback_res_off, sub_osc_stop};
   wire [7:0] rd_sclk = {2'h0, cur_sel.sub_clock_sel,
                         sel_sw.sub_clock_sel, 4'h0};
   wire [7:0] rd_val = (REG_ADDR == `CCG_ADDR_PROC_CLK) ? rd_proc :
                       (REG_ADDR == `CCG_ADDR_SUB_OSC)  ? rd_sosc :
                       (REG_ADDR == `CCG_ADDR_SUBCLK)   ? rd_sclk : 8'h00;

   always_comb begin
      next_state = state;
      unique case (state)
         ccg_pkg::ST_OFF:  next_state = ccg_pkg::ST_STAB;
         ccg_pkg::ST_STAB: if (stab_done) next_state = ccg_pkg::ST_RUN;
         ccg_pkg::ST_RUN:  if (stop_ok) next_state = ccg_pkg::ST_STOP;
         ccg_pkg::ST_STOP: if (WAKE_REQ) next_state = ccg_pkg::ST_STAB;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN)
         state <= ccg_pkg::ST_OFF;
      else
         state <= next_state;
   end

   // Software registers
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         main_osc_stop         <= 1'(`CCG_PROC_CLK_RESET >> `CCG_BIT_MAIN_STOP);
         sel_sw.cpu_div_sel    <= 1'(`CCG_PROC_CLK_RESET >> `CCG_BIT_DIV_SEL);
         sel_sw.sub_clock_sel  <= 1'(`CCG_SUBCLK_RESET >> `CCG_BIT_SUB_SEL);
         feedback_res_off      <= 1'(`CCG_SUB_OSC_RESET >> `CCG_BIT_FB_RES);
         sub_osc_stop          <= 1'(`CCG_SUB_OSC_RESET >> `CCG_BIT_SUB_STOP);
      end else begin
         if (wr_proc) begin
            main_osc_stop      <= REG_WDATA[`CCG_BIT_MAIN_STOP];
            sel_sw.cpu_div_sel <= REG_WDATA[`CCG_BIT_DIV_SEL];
         end
         if (wr_sclk)
            sel_sw.sub_clock_sel <= REG_WDATA[`CCG_BIT_SUB_SEL];
         if (wr_sosc) begin
            feedback_res_off   <= REG_WDATA[`CCG_BIT_FB_RES];
            sub_osc_stop       <= REG_WDATA[`CCG_BIT_SUB_STOP];
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN)
         REG_RDATA <= 8'h00;
      else
         REG_RDATA <= REG_RD ? rd_val : 8'h00;
   end

   // Selection in force; it moves only on a tick of the old clock, which
   // ends that clock's period cleanly before the new source takes over
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         cur_sel.sub_clock_sel <= 1'(`CCG_SUBCLK_RESET >> `CCG_BIT_SUB_SEL);
         cur_sel.cpu_div_sel   <= 1'(`CCG_PROC_CLK_RESET >> `CCG_BIT_DIV_SEL);
         sw_cnt                <= 9'h000;
      end else if (!sw_pend || wr_proc || wr_sclk) begin
         sw_cnt <= 9'h000;
      end else if (sw_done) begin
         cur_sel <= sel_sw;
         sw_cnt  <= 9'h000;
      end else if (cpu_src_tick) begin
         sw_cnt <= 9'(sw_cnt + 9'h001);
      end
   end

   // Start-up wait counter in main oscillator periods
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN)
         stab_cnt <= 16'h0000;
      else if (state != ccg_pkg::ST_STAB)
         stab_cnt <= 16'h0000;
      else if (main_tick)
         stab_cnt <= 16'(stab_cnt + 16'h0001);
   end

   // Frequency dividers on the oscillator ticks
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         main_div <= 2'h0;
         sub_half <= 1'b0;
         pdiv     <= 8'h00;
      end else begin
         if (main_tick) begin
            main_div <= 2'(main_div + 2'h1);
            pdiv     <= 8'(pdiv + 8'h01);
         end
         if (sub_tick)
            sub_half <= !sub_half;
      end
   end

   // Peripheral enable i fires once per 2^(i+1) main ticks; a genvar keeps
   // the part-select of the divider constant for every bit
   logic [7:0] next_periph;
   for (genvar i = 0; i < 8; i++) begin : g_periph
      assign next_periph[i] = main_tick && (&pdiv[i:0]);
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         MAIN_OSC_EN     <= 1'b0;
         SUB_OSC_EN      <= 1'b0;
         FEEDBACK_RES_EN <= 1'b0;
         STOP_MODE       <= 1'b0;
         HALT_MODE       <= 1'b0;
         CPU_RUN         <= 1'b0;
         CPU_CLK_EN      <= 1'b0;
         PERIPH_CLK_EN   <= 8'h00;
         PERIPH_RUN      <= 1'b0;
         WATCH_CLK_EN    <= 1'b0;
      end else begin
         MAIN_OSC_EN     <= main_on;
         SUB_OSC_EN      <= !sub_osc_stop;
         FEEDBACK_RES_EN <= !feedback_res_off;
         STOP_MODE       <= (next_state == ccg_pkg::ST_STOP);
         HALT_MODE       <= WAKE_REQ ? 1'b0 : (HALT_MODE || halt_ok);
         CPU_RUN         <= (next_state == ccg_pkg::ST_RUN);
         CPU_CLK_EN      <= cpu_src_tick && (state == ccg_pkg::ST_RUN) &&
                            !HALT_MODE && !halt_ok;
         PERIPH_CLK_EN   <= next_periph;
         PERIPH_RUN      <= main_on;
         WATCH_CLK_EN    <= sub_tick;
      end
   end

   reset_sel_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      state == ccg_pkg::ST_OFF |-> cur_sel.cpu_div_sel && !cur_sel.sub_clock_sel)
      else $error("reset selection is not main divided by four");

   osc_reset_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      state == ccg_pkg::ST_OFF |-> !MAIN_OSC_EN)
      else $error("main oscillator enabled during reset");

   stop_refused_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      STOP_REQ && cur_sel.sub_clock_sel && !STOP_MODE |=> !STOP_MODE)
      else $error("stop mode entered on subsystem clock");

   halt_taken_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      HALT_REQ && state == ccg_pkg::ST_RUN && !WAKE_REQ |=> HALT_MODE ##0 !CPU_CLK_EN)
      else $error("halt request not honoured");

   fb_res_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      wr_sosc && REG_WDATA[`CCG_BIT_FB_RES] |=> ##1 !FEEDBACK_RES_EN)
      else $error("feedback resistor still connected");

   sub_stop_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      wr_sosc && REG_WDATA[`CCG_BIT_SUB_STOP] |=> ##1 !SUB_OSC_EN ##1 !WATCH_CLK_EN)
      else $error("subsystem oscillator still running");

   switch_delay_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      $changed(cur_sel) |-> $past(sw_cnt) == 9'($past(sw_max) - 9'h001))
      else $error("clock switched after wrong delay");

   switch_safe_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      $changed(cur_sel) |-> $past(cpu_src_tick))
      else $error("clock switched between old clock ticks");

   stab_wait_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      $rose(CPU_RUN) |-> $past(stab_cnt, 2) == 16'(STAB_MAIN_TICKS - 1))
      else $error("CPU started before stabilisation wait");

   main_stop_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      main_osc_stop && cur_sel.sub_clock_sel && state == ccg_pkg::ST_RUN
      |=> !MAIN_OSC_EN ##1 PERIPH_CLK_EN == 8'h00)
      else $error("main oscillator not stopped");
endmodule

/* verif/ccg_osc_model.sv */
// Behavioural crystal oscillator that stands still while its enable is low
`timescale 1ns/1ps
module ccg_osc_model #(
   parameter real HALF = 20.0
) (
   input  wire logic en,
   output logic      osc
);
   // Odd start offset keeps oscillator edges away from system clock edges
   initial begin
      osc = 1'b0;
      #1.3;
      forever begin
         #(HALF);
         osc = en ? ~osc : 1'b0;
      end
   end
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the CPU clock generator with a register model
`timescale 1ns/1ps
module tb_top;
   logic        clk_sys, resetn, wr, rd, stop_req, halt_req, wake_req;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata, pclk_en;
   logic        main_in, sub_in, main_en, sub_en, fb_en, stop_md, halt_md;
   logic        cpu_run, cpu_en, p_run, w_en;
   int          fail_count = 0, comparisons = 0, ticks = 0, pticks = 0, wticks = 0;
   int          mdl [3];
   int          cpu_source_status;

   ccg_top #(.STAB_MAIN_TICKS(8)) i_ccg_top (
      .CLK_SYS(clk_sys), .RESETN(resetn), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .MAIN_OSC_IN(main_in),
      .SUB_OSC_IN(sub_in), .MAIN_OSC_EN(main_en), .SUB_OSC_EN(sub_en),
      .FEEDBACK_RES_EN(fb_en), .STOP_REQ(stop_req), .HALT_REQ(halt_req),
      .WAKE_REQ(wake_req), .STOP_MODE(stop_md), .HALT_MODE(halt_md), .CPU_RUN(cpu_run),
      .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(pclk_en), .PERIPH_RUN(p_run),
      .WATCH_CLK_EN(w_en));
   // Main period is 8 system cycles, subsystem period 80
   ccg_osc_model #(.HALF(20.0)) i_main_osc (.en(main_en), .osc(main_in));
   ccg_osc_model #(.HALF(200.0)) i_sub_osc (.en(sub_en), .osc(sub_in));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      ticks <= ticks + (cpu_en === 1'b1);
      pticks <= pticks + (pclk_en[0] === 1'b1);
      wticks <= wticks + (w_en === 1'b1);
   end

   task automatic wrap_up;
      if (fail_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic check_rng(input string what, input int lo, input int hi, input int got);
      comparisons++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, got);
      end
   endtask

   task automatic idle(input int c);
      repeat (c) @(posedge clk_sys);
   endtask

   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      case (a)
         16'hFFFB: mdl[0] = d & 8'h82;
         16'hFFF0: mdl[1] = d & 8'h03;
         16'hFFF2: mdl[2] = d & 8'h10;
         default: ;
      endcase
   endtask

   task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      d = rdata;
   endtask

   task automatic reg_chk(input logic [15:0] a);
      logic [7:0] d;
      int         e;
      reg_rd(a, d);
      e = a == 16'hFFFB ? mdl[0] : a == 16'hFFF0 ? mdl[1] : a == 16'hFFF2 ? mdl[2] | cpu_source_status << 5 : 0;
      check("register", e, d);
   endtask

   function automatic logic pulse(input int w);
      return w == 0 ? cpu_en : w == 1 ? pclk_en[0] : pclk_en[2];
   endfunction

   // Cycles between two consecutive pulses of the chosen clock enable
   task automatic period(input int w, input int exp);
      int k, n;
      k = 0;
      n = 0;
      @(negedge clk_sys);
      while (pulse(w) !== 1'b1 && k < 2000) begin
         @(negedge clk_sys);
         k++;
      end
      do begin
         @(negedge clk_sys);
         n++;
      end while (pulse(w) !== 1'b1 && n < 2000);
      check("period", exp, n);
   endtask

   // Counts old CPU ticks until the status bit shows the new source
   task automatic switch(input logic [15:0] a, input logic [7:0] d, input int n, input int s);
      logic [7:0] r;
      int         t0, k;
      reg_wr(a, d);
      t0 = ticks;
      k = 0;
      do begin
         reg_rd(16'hFFF2, r);
         k++;
      end while (r[5] !== s[0] && k < 3000);
      check_rng("switch delay", n - 1, n + 1, ticks - t0);
      cpu_source_status = s;
   endtask

   task automatic req(input int w);
      @(posedge clk_sys);
      stop_req <= (w == 0);
      halt_req <= (w == 1);
      wake_req <= (w == 2);
      @(posedge clk_sys);
      {stop_req, halt_req, wake_req} <= 3'b000;
      @(negedge clk_sys);
   endtask

   task automatic wait_run;
      int k;
      k = 0;
      while (!(cpu_run === 1'b1 && stop_md === 1'b0) && k < 5000) begin
         @(negedge clk_sys);
         k++;
      end
      check("cpu run", 1, cpu_run);
   endtask

   initial begin
      logic [7:0] r;
      int         t, w;
      {resetn, wr, rd, stop_req, halt_req, wake_req, addr, wdata} = '0;
      mdl = '{2, 0, 0};
      cpu_source_status = 0;
      void'($urandom(32'h90d5));
      idle(8);
      check("osc in reset", 0, main_en);
      idle(8);
      resetn <= 1'b1;
      reg_chk(16'hFFFB);
      reg_chk(16'hFFF0);
      reg_chk(16'hFFF2);
      wait_run;
      period(0, 32);
      period(1, 16);
      period(2, 64);
      repeat (6) begin
         r = 8'($urandom);
         reg_wr(16'hFFF0, r);
         reg_chk(16'hFFF0);
         check("sub osc enable", !r[0], sub_en);
         check("feedback", !r[1], fb_en);
         reg_chk({8'hF0, r});
      end
      reg_wr(16'hFFF0, 8'h00);
      idle(400);
      reg_wr(16'hFFFB, 8'h00);
      idle(100);
      period(0, 8);
      reg_wr(16'hFFFB, 8'h02);
      idle(100);
      period(0, 32);
      reg_wr(16'hFFFB, 8'h00);
      idle(100);
      switch(16'hFFF2, 8'h10, 306, 1);
      period(0, 160);
      reg_chk(16'hFFF2);
      req(0);
      check("stop refused", 0, stop_md);
      req(1);
      check("halt", 1, halt_md);
      t = ticks;
      idle(400);
      check("halted ticks", 0, ticks - t);
      req(2);
      check("halt released", 0, halt_md);
      reg_wr(16'hFFFB, 8'h80);
      idle(20);
      check("main stopped", 0, main_en);
      check("periph run", 0, p_run);
      t = pticks;
      w = wticks;
      idle(400);
      check("periph ticks", 0, pticks - t);
      check("watch runs", 1, wticks - w > 4);
      reg_wr(16'hFFFB, 8'h00);
      idle(20);
      check("main restarted", 1, main_en);
      idle(400);
      switch(16'hFFF2, 8'h00, 2, 0);
      period(0, 8);
      req(1);
      check("halt on main", 1, halt_md);
      req(2);
      req(0);
      check("stop on main", 1, stop_md);
      idle(10);
      check("stop osc off", 0, main_en);
      req(2);
      wait_run;
      @(posedge clk_sys);
      resetn <= 1'b0;
      mdl = '{2, 0, 0};
      cpu_source_status = 0;
      idle(4);
      resetn <= 1'b1;
      reg_chk(16'hFFFB);
      reg_chk(16'hFFF2);
      wrap_up;
   end

   // The whole sequence needs roughly 5700 cycles; the limit allows about seven times that
   initial begin
      #200000;
      fail_count++;
      wrap_up;
   end
endmodule
